// file: src/annp_regs.sv
`timescale 1ns/100ps
`include "annp_cfg.svh"
module annp_regs (
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    input  wire logic        i_mgmt_wr,
    input  wire logic        i_mgmt_rd,
    input  wire logic [4:0]  i_mgmt_addr,
    input  wire logic [15:0] i_mgmt_wdata,
    output logic      [15:0] o_mgmt_rdata,
    input  wire logic        i_base_sent,
    input  wire logic        i_base_bit11,
    input  wire logic        i_np_sent,
    output logic      [15:0] o_np_tx_word,
    input  wire logic        i_np_rx_valid,
    input  wire logic [15:0] i_np_rx_word,
    output logic             o_page_rx
);
    annp_pkg::annp_state_t st_reg;
    annp_pkg::annp_state_t st_next;
    logic toggle;
    // decoded strobes: wr_tx and rd_exp feed the next-state logic, all four feed the checks
    logic wr_tx;
    logic rd_tx;
    logic rd_exp;
    logic rd_partner;

    // one register selected by a live strobe
    function automatic logic addr_is(input logic strobe, input logic [4:0] addr, input logic [4:0] target);
        return strobe && (addr == target);
    endfunction

    assign wr_tx      = addr_is(i_mgmt_wr, i_mgmt_addr, `ANNP_ADDR_TX);
    assign rd_tx      = addr_is(i_mgmt_rd, i_mgmt_addr, `ANNP_ADDR_TX);
    assign rd_exp     = addr_is(i_mgmt_rd, i_mgmt_addr, `ANNP_ADDR_EXP);
    assign rd_partner = addr_is(i_mgmt_rd, i_mgmt_addr, `ANNP_ADDR_PARTNER);

    annp_toggle u_toggle (
        .i_clk_sys    (i_clk_sys),
        .i_sys_rst    (i_sys_rst),
        .i_base_sent  (i_base_sent),
        .i_base_bit11 (i_base_bit11),
        .i_np_sent    (i_np_sent),
        .o_toggle     (toggle)
    );

    function automatic logic [15:0] tx_view(input logic [15:0] w, input logic t);
        logic [15:0] v;
        v = w & `ANNP_TX_WR_MASK;
        v[`ANNP_BIT_TOGGLE] = t;
        return v;
    endfunction

    always_comb begin
        st_next = st_reg;
        st_next.toggle = toggle;
        // only the flag and code bits take write data
        if (wr_tx) begin
            st_next.tx_word = i_mgmt_wdata & `ANNP_TX_WR_MASK; // [R11]
        end
        if (i_base_sent) begin
            st_next.first_np = 1'b1;
        end else if (i_np_sent) begin
            st_next.first_np = 1'b0;
        end
        if (rd_exp) begin
            st_next.page_rx = 1'b0; // [R12]
        end
        // a reception in the same cycle as the clearing read wins
        if (i_np_rx_valid) begin
            st_next.partner_word = i_np_rx_word & `ANNP_PARTNER_MASK; // [R13] [R4] [R5] [R6] [R7] [R8]
            st_next.page_rx = 1'b1; // [R12]
        end
        st_next.rd_data = 16'h0000;
        if (i_mgmt_rd) begin
            unique case (i_mgmt_addr)
                `ANNP_ADDR_TX:      st_next.rd_data = tx_view(st_reg.tx_word, toggle);
                `ANNP_ADDR_PARTNER: st_next.rd_data = st_reg.partner_word; // [R10]
                `ANNP_ADDR_EXP: begin
                    st_next.rd_data = 16'h0000;
                    st_next.rd_data[`ANNP_BIT_PAGE_RX] = st_reg.page_rx;
                end
                default:            st_next.rd_data = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            st_reg.tx_word      <= `ANNP_TX_RESET;
            st_reg.toggle       <= 1'b0;
            st_reg.first_np     <= 1'b0;
            st_reg.partner_word <= 16'h0000;
            st_reg.page_rx      <= 1'b0;
            st_reg.rd_data      <= 16'h0000;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_mgmt_rdata = st_reg.rd_data;
    assign o_np_tx_word = tx_view(st_reg.tx_word, toggle); // [R3] [R1]
    assign o_page_rx    = st_reg.page_rx;

    // transmit register: written fields go out unchanged, fixed bits stay fixed
    AST_CODE_COPY: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R3]
        wr_tx |=> o_np_tx_word[`ANNP_CODE_MSB:0] == $past(i_mgmt_wdata[`ANNP_CODE_MSB:0]))
        else $error("transmit code field mismatch");

    // each code bit holds between writes, whatever the toggle does
    for (genvar gi = 0; gi <= `ANNP_CODE_MSB; gi = gi + 1) begin : g_code_bit
        AST_CODE_BIT: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R3]
            !wr_tx |=> $stable(o_np_tx_word[gi]))
            else $error("transmit code bit changed without a write");
    end

    // flags of the outgoing word follow the last write
    AST_TX_FLAGS_COPY: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R11]
        wr_tx |=> o_np_tx_word[`ANNP_BIT_MORE] == $past(i_mgmt_wdata[`ANNP_BIT_MORE])
            && o_np_tx_word[`ANNP_BIT_FORMAT] == $past(i_mgmt_wdata[`ANNP_BIT_FORMAT])
            && o_np_tx_word[`ANNP_BIT_SECOND_ACKNOWLEDGE_FLAG] == $past(i_mgmt_wdata[`ANNP_BIT_SECOND_ACKNOWLEDGE_FLAG]))
        else $error("transmit flag bits not taken from the write");

    AST_TX_RSVD_LOW: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R11]
        !o_np_tx_word[`ANNP_BIT_RSVD])
        else $error("transmit reserved bit set");

    // writes aimed at other addresses must leave the transmit word alone
    AST_TX_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R11]
        !wr_tx |=> $stable(st_reg.tx_word))
        else $error("transmit word changed without a write");

    // read-only bits of the transmit register show the fixed zero and the live toggle
    AST_TX_RO_BITS: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R11]
        rd_tx |=> !o_mgmt_rdata[`ANNP_BIT_RSVD]
            && o_mgmt_rdata[`ANNP_BIT_TOGGLE] == $past(toggle))
        else $error("transmit register read-only bits wrong");

    // a read of the transmit register shows exactly the word on its way out
    AST_TX_READBACK: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R11]
        rd_tx |=> o_mgmt_rdata == $past(o_np_tx_word))
        else $error("transmit register read differs from word sent");

    // toggle: the copy of the previous value lets a sent page be judged against it
    AST_TOGGLE_PREV: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R1]
        (i_np_sent && !i_base_sent) |=> toggle != st_reg.toggle)
        else $error("toggle equals the value of the page before");

    AST_TOGGLE_IDLE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R1]
        !(i_np_sent || i_base_sent) |=> $stable(toggle))
        else $error("toggle moved with no page sent");

    // until the first next page goes out the loaded toggle must not move
    AST_FIRST_NP_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R2]
        (st_reg.first_np && !i_base_sent && !i_np_sent) |=> (st_reg.first_np && $stable(toggle)))
        else $error("first next page toggle lost before sending");

    // partner register: every field but reserved bit 14 taken from the word that was offered
    AST_PARTNER_CAPTURE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R4]
        i_np_rx_valid |=> st_reg.partner_word[`ANNP_CODE_MSB:0] == $past(i_np_rx_word[`ANNP_CODE_MSB:0]))
        else $error("partner code field not captured");

    AST_PARTNER_MORE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R5]
        i_np_rx_valid |=> st_reg.partner_word[`ANNP_BIT_MORE] == $past(i_np_rx_word[`ANNP_BIT_MORE]))
        else $error("partner more-pages flag not captured");

    AST_PARTNER_FLAGS: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R6]
        i_np_rx_valid |=> st_reg.partner_word[`ANNP_BIT_FORMAT] == $past(i_np_rx_word[`ANNP_BIT_FORMAT]))
        else $error("partner page-format flag not captured");

    AST_PARTNER_SECOND_ACKNOWLEDGE_FLAG: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R7]
        i_np_rx_valid |=> st_reg.partner_word[`ANNP_BIT_SECOND_ACKNOWLEDGE_FLAG] == $past(i_np_rx_word[`ANNP_BIT_SECOND_ACKNOWLEDGE_FLAG]))
        else $error("partner second-acknowledge flag not captured");

    // the partner toggle is stored as received, so the whole word lands together
    AST_PARTNER_WHOLE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R13]
        i_np_rx_valid |=> st_reg.partner_word[`ANNP_BIT_TOGGLE] == $past(i_np_rx_word[`ANNP_BIT_TOGGLE]))
        else $error("partner toggle bit not captured");

    AST_RSVD_ZERO: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R8]
        rd_partner |=> !o_mgmt_rdata[`ANNP_BIT_RSVD])
        else $error("reserved bit read nonzero");

    AST_PARTNER_RSVD_STORE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R8]
        !st_reg.partner_word[`ANNP_BIT_RSVD])
        else $error("reserved bit stored nonzero");

    // nothing but a reception may change the stored word, so reads never see a mix
    AST_PARTNER_STABLE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R13]
        !i_np_rx_valid |=> $stable(st_reg.partner_word))
        else $error("partner word changed without reception");

    AST_PARTNER_READ: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R10]
        rd_partner |=> o_mgmt_rdata == $past(st_reg.partner_word))
        else $error("partner register read wrong");

    // read data lasts one cycle and is zero otherwise
    AST_RDATA_IDLE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R10]
        !i_mgmt_rd |=> o_mgmt_rdata == 16'h0000)
        else $error("read data not zero outside a read");

    // watched through reset itself, so no disable here
    AST_PARTNER_RESET: assert property (@(posedge i_clk_sys) // [R10]
        i_sys_rst |=> (st_reg.partner_word == 16'h0000 && !o_page_rx))
        else $error("partner register not cleared by reset");

    // page received: set by a reception, cleared only by reading expansion
    AST_PAGE_RX_SET: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R12]
        i_np_rx_valid |=> o_page_rx)
        else $error("page received not set");

    AST_PAGE_RX_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R12]
        (o_page_rx && !rd_exp) |=> o_page_rx)
        else $error("page received cleared without expansion read");

    AST_PAGE_RX_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R12]
        (rd_exp && !i_np_rx_valid) |=> !o_page_rx)
        else $error("page received not cleared by expansion read");

    AST_EXP_READ: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R12]
        rd_exp |=> o_mgmt_rdata[`ANNP_BIT_PAGE_RX] == $past(o_page_rx))
        else $error("expansion read does not show page received");
endmodule

// file: include/annp_cfg.svh
// Behaviour
// R1: toggle bit inverts on every next page word transmitted; with a base page in the same cycle the code loads the inverse of bit 11.
// R2: first next page toggle is inverse of base page bit 11.
// R3: code field of transmit register copied into sent word bits 10:0.
// R4: partner code field appears in partner register bits 10:0.
// R5: partner more-pages flag appears in partner register bit 15.
// R6: partner page-format flag appears in partner register bit 13.
// R7: partner second-acknowledge flag appears in partner register bit 12.
// R8: reserved bit 14 of partner register always reads zero.
// R9: management writes reserved bits at their defaults on every write.
// R10: partner register at address 8, read-only, resets to zero.
// R11: transmit register at address 7; toggle and reserved bits read-only.
// R12: page-received flag latches on new word, clears on expansion read.
// R13: partner register updates whole word at once on reception.
`ifndef ANNP_CFG_SVH
`define ANNP_CFG_SVH
`define ANNP_ADDR_EXP       5'h06
`define ANNP_ADDR_TX        5'h07
`define ANNP_ADDR_PARTNER   5'h08
`define ANNP_BIT_MORE       15
`define ANNP_BIT_RSVD       14
`define ANNP_BIT_FORMAT     13
`define ANNP_BIT_SECOND_ACKNOWLEDGE_FLAG       12
`define ANNP_BIT_TOGGLE     11
`define ANNP_CODE_MSB       10
`define ANNP_BIT_PAGE_RX    1
`define ANNP_TX_RESET       16'h2001
`define ANNP_TX_WR_MASK     16'hB7FF
`define ANNP_PARTNER_MASK   16'hBFFF
`endif

// file: include/annp_pkg.sv
package annp_pkg;
    typedef struct packed {
        logic [15:0] tx_word;
        logic        toggle;
        logic        first_np;
        logic [15:0] partner_word;
        logic        page_rx;
        logic [15:0] rd_data;
    } annp_state_t;
endpackage

// file: src/annp_toggle.sv
`timescale 1ns/100ps
`include "annp_cfg.svh"
module annp_toggle (
    input  wire logic i_clk_sys,
    input  wire logic i_sys_rst,
    input  wire logic i_base_sent,
    input  wire logic i_base_bit11,
    input  wire logic i_np_sent,
    output logic      o_toggle
);
    logic toggle_reg;
    logic toggle_next;
    always_comb begin
        toggle_next = toggle_reg;
        if (i_base_sent) begin
            toggle_next = ~i_base_bit11; // [R2]
        end else if (i_np_sent) begin
            toggle_next = ~toggle_reg; // [R1]
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            toggle_reg <= 1'b0;
        end else begin
            toggle_reg <= toggle_next;
        end
    end
    assign o_toggle = toggle_reg;
    AST_TOGGLE_FLIP: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R1]
        (i_np_sent && !i_base_sent) |=> (o_toggle != $past(o_toggle)))
        else $error("toggle did not invert after next page");
    AST_TOGGLE_INIT: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R2]
        i_base_sent |=> (o_toggle == !$past(i_base_bit11)))
        else $error("initial toggle not inverse of base bit 11");
endmodule

// file: test/annp_partner.sv
`timescale 1ns/100ps
module annp_link_partner (
    input  wire logic        i_clk_sys,
    output logic             o_rx_valid,
    output logic      [15:0] o_rx_word,
    output logic             o_base_sent,
    output logic             o_base_bit11,
    output logic             o_np_sent
);
    initial begin
        {o_rx_valid, o_base_sent, o_base_bit11, o_np_sent} = 4'h0;
        o_rx_word = 16'h0000;
    end
    // whole word offered for one cycle, then the bus shows its inverse
    task automatic send_rx(input logic [15:0] w);
        @(negedge i_clk_sys) o_rx_word = w;
        o_rx_valid = 1'b1;
        @(negedge i_clk_sys) o_rx_valid = 1'b0;
        o_rx_word = ~w;
    endtask
    task automatic send_page(input logic base, input logic b11);
        @(negedge i_clk_sys) o_base_sent = base;
        o_np_sent = ~base;
        o_base_bit11 = b11;
        @(negedge i_clk_sys) {o_base_sent, o_np_sent} = 2'h0;
        o_base_bit11 = ~b11;
    endtask
    // base page and next page in one cycle: the base load must win
    task automatic send_both(input logic b11);
        @(negedge i_clk_sys) {o_base_sent, o_np_sent} = 2'h3;
        o_base_bit11 = b11;
        @(negedge i_clk_sys) {o_base_sent, o_np_sent} = 2'h0;
        o_base_bit11 = ~b11;
    endtask
endmodule

// file: test/testbench.sv
`timescale 1ns/100ps
`include "annp_cfg.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t got %h want %h", $time, (a), (e)); end end
module testbench;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_mgmt_wr = 1'b0;
    logic i_mgmt_rd = 1'b0;
    logic [4:0] i_mgmt_addr = 5'h00;
    logic [15:0] i_mgmt_wdata = 16'h0000;
    logic [15:0] o_mgmt_rdata, o_np_tx_word, rx_word;
    logic o_page_rx, rx_valid, base_sent, base_bit11, np_sent;
    int miscompares = 0;
    int samples_checked = 0;
    always #2 i_clk_sys = ~i_clk_sys;
    annp_regs dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_mgmt_wr(i_mgmt_wr), .i_mgmt_rd(i_mgmt_rd),
        .i_mgmt_addr(i_mgmt_addr), .i_mgmt_wdata(i_mgmt_wdata), .o_mgmt_rdata(o_mgmt_rdata),
        .i_base_sent(base_sent), .i_base_bit11(base_bit11), .i_np_sent(np_sent), .o_np_tx_word(o_np_tx_word),
        .i_np_rx_valid(rx_valid), .i_np_rx_word(rx_word), .o_page_rx(o_page_rx));
    annp_link_partner partner (.i_clk_sys(i_clk_sys), .o_rx_valid(rx_valid), .o_rx_word(rx_word),
        .o_base_sent(base_sent), .o_base_bit11(base_bit11), .o_np_sent(np_sent));
    task automatic mgmt(input logic wr, input logic [4:0] a, input logic [15:0] d, input logic [15:0] exp);
        @(negedge i_clk_sys) {i_mgmt_wr, i_mgmt_rd} = {wr, ~wr};
        i_mgmt_addr = a;
        i_mgmt_wdata = d;
        @(negedge i_clk_sys) {i_mgmt_wr, i_mgmt_rd} = 2'h0;
        if (!wr) `CHK(o_mgmt_rdata, exp)
    endtask
    task automatic check_reset();
        mgmt(1'b0, `ANNP_ADDR_TX, 16'h0000, `ANNP_TX_RESET);
        mgmt(1'b0, `ANNP_ADDR_PARTNER, 16'h0000, 16'h0000);
        mgmt(1'b0, 5'h1F, 16'h0000, 16'h0000);
    endtask
    task automatic check_tx_write();
        mgmt(1'b1, `ANNP_ADDR_TX, 16'hBFFF, 16'h0000);
        mgmt(1'b0, `ANNP_ADDR_TX, 16'h0000, 16'hB7FF);
        `CHK(o_np_tx_word, 16'hB7FF)
        mgmt(1'b1, `ANNP_ADDR_TX, 16'h0555, 16'h0000);
        `CHK(o_np_tx_word, 16'h0555)
    endtask
    task automatic check_toggle();
        partner.send_page(1'b1, 1'b0);
        `CHK(o_np_tx_word[11], 1'b1)
        partner.send_page(1'b0, 1'b0);
        `CHK(o_np_tx_word[11], 1'b0)
        partner.send_page(1'b0, 1'b0);
        `CHK(o_np_tx_word[11], 1'b1)
        partner.send_page(1'b1, 1'b1);
        `CHK(o_np_tx_word, 16'h0555)
        partner.send_page(1'b0, 1'b0);
        `CHK(o_np_tx_word[11], 1'b1)
        partner.send_both(1'b0);
        `CHK(o_np_tx_word, 16'h0D55)
    endtask
    task automatic check_rx();
        partner.send_rx(16'hFFFF);
        `CHK(o_page_rx, 1'b1)
        mgmt(1'b0, `ANNP_ADDR_PARTNER, 16'h0000, 16'hBFFF);
        mgmt(1'b1, `ANNP_ADDR_PARTNER, 16'h0000, 16'h0000);
        mgmt(1'b0, `ANNP_ADDR_PARTNER, 16'h0000, 16'hBFFF);
        partner.send_rx(16'h4A5A);
        mgmt(1'b0, `ANNP_ADDR_PARTNER, 16'h0000, 16'h0A5A);
        mgmt(1'b0, `ANNP_ADDR_EXP, 16'h0000, 16'h0002);
        `CHK(o_page_rx, 1'b0)
        mgmt(1'b0, `ANNP_ADDR_EXP, 16'h0000, 16'h0000);
    endtask
    task automatic check_mid_reset();
        partner.send_rx(16'h9234);
        @(negedge i_clk_sys) i_sys_rst = 1'b1;
        repeat (2) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        `CHK(o_page_rx, 1'b0)
        `CHK(o_np_tx_word, `ANNP_TX_RESET)
        mgmt(1'b0, `ANNP_ADDR_PARTNER, 16'h0000, 16'h0000);
    endtask
    task automatic wrap_up();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        check_reset();
        check_tx_write();
        check_toggle();
        check_rx();
        check_mid_reset();
        wrap_up();
    end
endmodule
